// file: rtl/dmc_defs.svh
// constants of the four-channel transfer engine: codes, address windows, counts
// assumes inclusion by its bare name from the package, the checker and the bench
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
`define DMC_NCH 4
`define DMC_AMODE_STATIC 2'h0
`define DMC_AMODE_INC 2'h1
`define DMC_AMODE_DEC 2'h2
`define DMC_RLD_NEVER 2'h0
`define DMC_RLD_BURST 2'h1
`define DMC_RLD_BLOCK 2'h2
`define DMC_RLD_TRANS 2'h3
`define DMC_PRIO_RR0123 2'h0
`define DMC_PRIO_CH0RR 2'h1
`define DMC_PRIO_CH01RR 2'h2
`define DMC_PRIO_FIXED 2'h3
`define DMC_LINK_CH01_BIT 0
`define DMC_LINK_CH23_BIT 1
`define DMC_EE_FIRST 16'h1000
`define DMC_EE_LAST 16'h1fff
`define DMC_TRIG_PRESENT 8'h7f
`define DMC_BLK_FULL 17'h10000
`endif

// file: rtl/dmc_pkg.sv
// types shared by the transfer engine modules
// assumes dmc_defs.svh on the include path
`include "dmc_defs.svh"
package dmc_pkg;
  typedef logic [15:0] dmc_addr_t;
  typedef logic [7:0] dmc_byte_t;
  typedef logic [16:0] dmc_blk_t;
  typedef enum logic [1:0] {
    DMC_IDLE,
    DMC_REQ,
    DMC_RD,
    DMC_WR
  } dmc_state_e;
endpackage : dmc_pkg

// file: rtl/dmc_buf.sv
// two-entry byte buffer between read and write side, registered output data
// assumes one clock; flush empties it in one cycle
module dmc_buf (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  input wire dmc_pkg::dmc_byte_t in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output dmc_pkg::dmc_byte_t out_data
);
  import dmc_pkg::*;
  dmc_byte_t mem [2];
  dmc_byte_t next_mem [2];
  logic wptr, rptr, next_wptr, next_rptr;
  logic [1:0] cnt, next_cnt;
  logic push, pop;

  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data = mem[rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_mem = mem;
    next_wptr = wptr;
    next_rptr = rptr;
    next_cnt = cnt;
    if (flush) begin
      next_wptr = 1'b0;
      next_rptr = 1'b0;
      next_cnt = 2'h0;
    end else begin
      if (push) begin
        next_mem[wptr] = in_data;
        next_wptr = ~wptr;
      end
      if (pop) begin
        next_rptr = ~rptr;
      end
      next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      wptr <= 1'b0;
      rptr <= 1'b0;
      cnt <= 2'h0;
    end else begin
      mem <= next_mem;
      wptr <= next_wptr;
      rptr <= next_rptr;
      cnt <= next_cnt;
    end
  end
endmodule : dmc_buf

// file: rtl/dmc_top.sv
// four-channel transfer engine: channel state, arbitration and byte mover
// assumes a shared bus arbiter that grants bus_gnt, and memories that answer
// a held mem_rd with mem_rvalid and a held mem_wr with mem_wack
module dmc_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [1:0] channel_priority_select,
  input wire logic [1:0] channel_pair_link_select,
  input wire logic [3:0] ch_enable_set,
  input wire logic [3:0] ch_enable_clr,
  output logic [3:0] ch_enabled,
  input wire logic [3:0] ch_single_shot,
  input wire logic [3:0] ch_repeat_en,
  input wire logic [3:0][7:0] ch_repeat_cnt,
  input wire logic [3:0][15:0] ch_block_cnt,
  input wire logic [3:0][1:0] ch_burst_len,
  input wire logic [3:0][1:0] ch_src_mode,
  input wire logic [3:0][1:0] ch_dst_mode,
  input wire logic [3:0][1:0] ch_src_reload,
  input wire logic [3:0][1:0] ch_dst_reload,
  input wire dmc_pkg::dmc_addr_t [3:0] ch_src_start,
  input wire dmc_pkg::dmc_addr_t [3:0] ch_dst_start,
  input wire logic [3:0][2:0] ch_trig_sel,
  input wire logic [3:0] sw_trig,
  input wire logic [7:0] trig_lines,
  input wire logic [3:0] trn_irq_en,
  input wire logic [3:0] err_irq_en,
  input wire logic [3:0] trn_flag_clr,
  input wire logic [3:0] err_flag_clr,
  output logic [3:0] trn_flag,
  output logic [3:0] err_flag,
  output logic [3:0] trn_irq,
  output logic [3:0] err_irq,
  output logic [3:0] ch_busy,
  output logic [3:0] ch_pend,
  input wire logic cpu_bus_req,
  output logic bus_req,
  input wire logic bus_gnt,
  output dmc_pkg::dmc_addr_t mem_addr,
  output logic mem_rd,
  input wire logic mem_rvalid,
  input wire dmc_pkg::dmc_byte_t mem_rdata,
  output logic mem_wr,
  input wire logic mem_wack,
  output dmc_pkg::dmc_byte_t mem_wdata
);
  import dmc_pkg::*;

  wire [3:0] rdy;
  wire [3:0] trn_end;
  wire dmc_addr_t [3:0] cur_src;
  wire dmc_addr_t [3:0] cur_dst;
  wire dmc_blk_t [3:0] cur_blk;
  dmc_state_e state, next_state;
  logic [1:0] sel, next_sel, last_ch, next_last_ch;
  logic [3:0] bcnt, next_bcnt;
  logic byte_done, burst_done, wr_err, buf_in_ready, buf_out_valid;
  logic [1:0] pick;
  logic found;
  logic [3:0] fixed;
  logic [3:0] burst_bytes;
  logic [1:0] idx;

  // per-channel state
  for (genvar g = 0; g < `DMC_NCH; g++) begin : gen_ch
    logic en, armed, pend, busy, trn_f, err_f;
    logic next_en, next_armed, next_pend, next_busy, next_trn_f, next_err_f;
    dmc_addr_t src, dst, next_src, next_dst;
    dmc_blk_t blk_rem, next_blk_rem;
    logic [7:0] rep_rem, next_rep_rem;
    logic trig, mine, blk_end, more_blk, link_go, trn_set, err_set;
    dmc_blk_t blk_load;
    localparam int PART = g ^ 1;
    localparam logic [7:0] PRES = `DMC_TRIG_PRESENT;

    assign blk_load = (ch_block_cnt[g] == 16'h0000) ? `DMC_BLK_FULL
                                                     : {1'b0, ch_block_cnt[g]};
    // a selected line only counts when its source module is present
    assign trig = sw_trig[g] | (PRES[ch_trig_sel[g]] & trig_lines[ch_trig_sel[g]]);
    assign mine = (sel == 2'(g));
    assign blk_end = burst_done & mine & (blk_rem == 17'h00001);
    assign more_blk = ch_repeat_en[g] & ((ch_repeat_cnt[g] == 8'h00) | (rep_rem > 8'h01));
    assign link_go = trn_end[PART] & channel_pair_link_select[g / 2];
    assign err_set = (wr_err & mine) | (ch_enable_clr[g] & busy);
    assign trn_end[g] = blk_end & ~more_blk;
    assign trn_set = trn_end[g] | (blk_end & ch_repeat_en[g] &
                     (ch_repeat_cnt[g] == 8'h00));
    assign rdy[g] = en & armed;
    assign cur_src[g] = src;
    assign cur_dst[g] = dst;
    assign cur_blk[g] = blk_rem;
    assign ch_enabled[g] = en;
    assign ch_busy[g] = busy;
    assign ch_pend[g] = pend;
    assign trn_flag[g] = trn_f;
    assign err_flag[g] = err_f;
    assign trn_irq[g] = trn_f & trn_irq_en[g];
    assign err_irq[g] = err_f & err_irq_en[g];

    always_comb begin
      next_en = en;
      next_armed = armed;
      next_pend = pend;
      next_busy = busy;
      next_src = src;
      next_dst = dst;
      next_blk_rem = blk_rem;
      next_rep_rem = rep_rem;
      if (en & trig) begin
        if (!armed) begin
          next_armed = 1'b1;
        end else if (!pend) begin
          next_pend = 1'b1;
        end
      end
      if (byte_done & mine) begin
        next_busy = 1'b1;
        next_blk_rem = blk_rem - 17'h00001;
        if (ch_src_mode[g] == `DMC_AMODE_INC) next_src = src + 16'h0001;
        if (ch_src_mode[g] == `DMC_AMODE_DEC) next_src = src - 16'h0001;
        if (ch_dst_mode[g] == `DMC_AMODE_INC) next_dst = dst + 16'h0001;
        if (ch_dst_mode[g] == `DMC_AMODE_DEC) next_dst = dst - 16'h0001;
      end
      if (burst_done & mine) begin
        if (ch_src_reload[g] == `DMC_RLD_BURST) next_src = ch_src_start[g];
        if (ch_dst_reload[g] == `DMC_RLD_BURST) next_dst = ch_dst_start[g];
        if (ch_single_shot[g]) begin
          next_armed = pend;
          next_pend = 1'b0;
        end
      end
      if (blk_end) begin
        if (ch_src_reload[g] == `DMC_RLD_BLOCK) next_src = ch_src_start[g];
        if (ch_dst_reload[g] == `DMC_RLD_BLOCK) next_dst = ch_dst_start[g];
        next_blk_rem = blk_load;
        if (more_blk) begin
          if (ch_repeat_cnt[g] != 8'h00) next_rep_rem = rep_rem - 8'h01;
          if (!ch_single_shot[g]) next_armed = 1'b1;
        end else begin
          if (ch_src_reload[g] == `DMC_RLD_TRANS) next_src = ch_src_start[g];
          if (ch_dst_reload[g] == `DMC_RLD_TRANS) next_dst = ch_dst_start[g];
          next_en = 1'b0;
          next_armed = 1'b0;
          next_pend = 1'b0;
          next_busy = 1'b0;
        end
      end
      if ((ch_enable_set[g] & ~en) | link_go) begin
        next_en = 1'b1;
        next_armed = link_go;
        next_pend = 1'b0;
        next_busy = 1'b0;
        next_src = ch_src_start[g];
        next_dst = ch_dst_start[g];
        next_blk_rem = blk_load;
        next_rep_rem = ch_repeat_cnt[g];
      end
      if (ch_enable_clr[g] | err_set) begin
        next_en = 1'b0;
        next_armed = 1'b0;
        next_pend = 1'b0;
        next_busy = 1'b0;
      end
      next_trn_f = (trn_f & ~trn_flag_clr[g]) | trn_set; // set beats clear
      next_err_f = (err_f & ~err_flag_clr[g]) | err_set;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        en <= 1'b0;
        armed <= 1'b0;
        pend <= 1'b0;
        busy <= 1'b0;
        trn_f <= 1'b0;
        err_f <= 1'b0;
        src <= 16'h0000;
        dst <= 16'h0000;
        blk_rem <= 17'h00000;
        rep_rem <= 8'h00;
      end else begin
        en <= next_en;
        armed <= next_armed;
        pend <= next_pend;
        busy <= next_busy;
        trn_f <= next_trn_f;
        err_f <= next_err_f;
        src <= next_src;
        dst <= next_dst;
        blk_rem <= next_blk_rem;
        rep_rem <= next_rep_rem;
      end
    end
  end

  // arbitration: fixed part in index order, the rest round robin after last_ch
  always_comb begin
    found = 1'b0;
    pick = 2'h0;
    idx = 2'h0;
    case (channel_priority_select)
      `DMC_PRIO_RR0123: fixed = 4'h0;
      `DMC_PRIO_CH0RR: fixed = 4'h1;
      `DMC_PRIO_CH01RR: fixed = 4'h3;
      `DMC_PRIO_FIXED: fixed = 4'hf;
      default: fixed = 4'hf;
    endcase
    for (int i = 0; i < `DMC_NCH; i++) begin
      if (!found && fixed[i] && rdy[i]) begin
        found = 1'b1;
        pick = 2'(i);
      end
    end
    for (int k = 1; k <= `DMC_NCH; k++) begin
      idx = last_ch + 2'(k);
      if (!found && !fixed[idx] && rdy[idx]) begin
        found = 1'b1;
        pick = idx;
      end
    end
  end

  assign burst_bytes = 4'h1 << ch_burst_len[pick];
  assign mem_addr = (state == DMC_WR) ? cur_dst[sel] : cur_src[sel];
  assign wr_err = (state == DMC_WR) && (cur_dst[sel] >= `DMC_EE_FIRST) &&
                  (cur_dst[sel] <= `DMC_EE_LAST);
  assign bus_req = (state != DMC_IDLE);
  assign mem_rd = (state == DMC_RD) & buf_in_ready;
  assign mem_wr = (state == DMC_WR) & buf_out_valid & ~wr_err;
  assign byte_done = mem_wr & mem_wack;
  assign burst_done = byte_done & (bcnt == 4'h1);

  dmc_buf u_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .flush(wr_err),
    .in_valid(mem_rd & mem_rvalid),
    .in_data(mem_rdata),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_ready(mem_wr & mem_wack),
    .out_data(mem_wdata)
  );

  // byte mover
  always_comb begin
    next_state = state;
    next_sel = sel;
    next_last_ch = last_ch;
    next_bcnt = bcnt;
    case (state)
      DMC_IDLE: begin
        if (found) begin
          next_sel = pick;
          next_last_ch = pick;
          next_bcnt = (cur_blk[pick] < {13'h0000, burst_bytes}) ? cur_blk[pick][3:0]
                                                                : burst_bytes;
          next_state = DMC_REQ;
        end
      end
      DMC_REQ: begin
        if (!rdy[sel]) begin
          next_state = DMC_IDLE;
        end else if (bus_gnt && !cpu_bus_req) begin
          next_state = DMC_RD;
        end
      end
      DMC_RD: begin
        if (mem_rd && mem_rvalid) next_state = DMC_WR;
      end
      DMC_WR: begin
        if (wr_err) begin
          next_state = DMC_IDLE;
        end else if (byte_done) begin
          next_bcnt = bcnt - 4'h1;
          next_state = (bcnt == 4'h1) ? DMC_IDLE : DMC_RD;
        end
      end
      default: next_state = DMC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= DMC_IDLE;
      sel <= 2'h0;
      last_ch <= 2'h3;
      bcnt <= 4'h0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      last_ch <= next_last_ch;
      bcnt <= next_bcnt;
    end
  end
endmodule : dmc_top

// file: sim/dmc_mem.sv
// memory and bus arbiter partner of the transfer engine
// assumes the engine holds mem_rd or mem_wr until answered
module dmc_mem (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic bus_req,
  output logic bus_gnt,
  input wire dmc_pkg::dmc_addr_t mem_addr,
  input wire logic mem_rd,
  output logic mem_rvalid,
  output dmc_pkg::dmc_byte_t mem_rdata,
  input wire logic mem_wr,
  output logic mem_wack,
  input wire dmc_pkg::dmc_byte_t mem_wdata,
  output int n_wr,
  output dmc_pkg::dmc_addr_t last_a,
  output dmc_pkg::dmc_byte_t last_d
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmc_pkg::*;
  logic [1:0] wt, next_wt;
  logic slow, next_slow;
  logic done_rd, done_wr;
  always_comb begin
    done_rd = mem_rd && (wt >= {1'b0, slow});
    done_wr = mem_wr && (wt >= {1'b0, slow});
    next_wt = ((mem_rd && !done_rd) || (mem_wr && !done_wr)) ? wt + 2'h1 : 2'h0;
    next_slow = slow ^ done_wr;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wt <= 2'h0;
      slow <= 1'b0;
      n_wr <= 0;
      last_a <= '0;
      last_d <= '0;
    end else begin
      wt <= next_wt;
      slow <= next_slow;
      if (done_wr) begin
        n_wr <= n_wr + 1;
        last_a <= mem_addr;
        last_d <= mem_wdata;
      end
    end
  end
  // grants whenever asked: holding off during processor traffic is up to the engine
  assign bus_gnt = bus_req;
  assign mem_rvalid = done_rd;
  assign mem_wack = done_wr;
  // data only meaningful with mem_rvalid, the inverse otherwise
  assign mem_rdata = (mem_addr[7:0] ^ 8'h5a) ^ {8{!done_rd}};
endmodule : dmc_mem

// file: sim/dmc_top_sva.sv
// checker of the engine's bus, memory and flag behaviour
// assumes binding to dmc_top; sees its ports only
`include "dmc_defs.svh"
module dmc_top_sva (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] ch_enable_clr,
  input wire logic [3:0] ch_enabled,
  input wire logic cpu_bus_req,
  input wire logic bus_req,
  input wire logic bus_gnt,
  input wire dmc_pkg::dmc_addr_t mem_addr,
  input wire logic mem_rd,
  input wire logic mem_rvalid,
  input wire logic mem_wr,
  input wire logic mem_wack,
  input wire dmc_pkg::dmc_byte_t mem_wdata,
  input wire logic [3:0] trn_flag,
  input wire logic [3:0] err_flag,
  input wire logic [3:0] trn_irq,
  input wire logic [3:0] err_irq,
  input wire logic [3:0] trn_irq_en,
  input wire logic [3:0] err_irq_en,
  input wire logic [3:0] trn_flag_clr
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_gnt_cpu_wait: assert property ($rose(mem_rd) && !$past(mem_wr) |->
    $past(bus_gnt && !cpu_bus_req)) else $error("burst started against processor");
  a_cpu_blocks_rd: assert property (cpu_bus_req && !mem_rd && !mem_wr |=> !mem_rd)
    else $error("read began while processor requests");
  a_rd_hold: assert property (mem_rd && !mem_rvalid |=> mem_rd && $stable(mem_addr))
    else $error("read dropped early");
  a_wr_hold: assert property (mem_wr && !mem_wack |=> mem_wr && $stable(mem_addr)
    && $stable(mem_wdata)) else $error("write dropped early");
  a_rd_to_wr: assert property (mem_rd && mem_rvalid |=> mem_wr ||
    (mem_addr inside {[`DMC_EE_FIRST:`DMC_EE_LAST]}))
    else $error("read not followed by write");
  a_bus_owned: assert property (mem_rd || mem_wr |-> bus_req)
    else $error("access without bus request");
  a_idle_gap: assert property ($fell(bus_req) |-> $past(mem_wr && mem_wack) ||
    $past(!mem_rd && !mem_wr)) else $error("bus released inside a transfer");
  a_no_ee_wr: assert property (mem_wr |->
    !(mem_addr inside {[`DMC_EE_FIRST:`DMC_EE_LAST]})) else $error("write into eeprom");
  a_irq_and: assert property (trn_irq == (trn_flag & trn_irq_en)
    && err_irq == (err_flag & err_irq_en)) else $error("irq not flag and enable");
  a_clr_off: assert property ((ch_enable_clr & ch_enabled) != 4'h0 |=>
    (ch_enabled & $past(ch_enable_clr)) == 4'h0) else $error("channel stayed on");
  a_flag_sticky: assert property (1'b1 |=> (trn_flag & $past(trn_flag & ~trn_flag_clr))
    == $past(trn_flag & ~trn_flag_clr)) else $error("flag lost");
  a_reset_clear: assert property ($rose(nrst) |-> ch_enabled == 4'h0)
    else $error("channel on after reset");
  c_write: cover property (mem_wr && mem_wack);
  c_error: cover property ($rose(err_flag != 4'h0));
  c_cpu_wait: cover property (cpu_bus_req && bus_req);
endmodule : dmc_top_sva
bind dmc_top dmc_top_sva chk (.*);

// file: sim/dmc_top_tb.sv
// self-checking bench of the four-channel transfer engine
// assumes dmc_top, its checker and the dmc_mem partner are compiled before it
`include "dmc_defs.svh"
module dmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dmc_pkg::*;
  logic ref_clk, nrst = 0, cpu_bus_req = 0, bus_req, bus_gnt, mem_rd, mem_rvalid, mem_wr, mem_wack;
  logic [1:0] channel_priority_select = 0, channel_pair_link_select = 0;
  logic [3:0] ch_enable_set = 0, ch_enable_clr = 0, ch_single_shot = 0, ch_repeat_en = 0;
  logic [3:0] sw_trig = 0, trn_irq_en = 0, err_irq_en = 0, trn_flag_clr = 0, err_flag_clr = 0;
  logic [3:0] ch_enabled, trn_flag, err_flag, trn_irq, err_irq, ch_busy, ch_pend;
  logic [3:0][7:0] ch_repeat_cnt = '0;
  logic [3:0][15:0] ch_block_cnt = '0;
  logic [3:0][1:0] ch_burst_len = '0, ch_src_mode = '0, ch_dst_mode = '0;
  logic [3:0][1:0] ch_src_reload = '0, ch_dst_reload = '0;
  dmc_addr_t [3:0] ch_src_start = '0, ch_dst_start = '0;
  logic [3:0][2:0] ch_trig_sel = '0;
  logic [7:0] trig_lines = 0;
  dmc_addr_t mem_addr, last_a;
  dmc_byte_t mem_rdata, mem_wdata, last_d;
  int n_wr, n0, n_fail = 0, n_checks = 0;
  dmc_top DUT (.*);
  dmc_mem mem (.*);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tk
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic dmc_byte_t f(input dmc_addr_t a);
    return a[7:0] ^ 8'h5a;
  endfunction : f
  task cfg(input int c, input logic [15:0] b, input logic [1:0] bl, input logic [1:0] sm,
           input logic [1:0] dm, input logic [1:0] dr, input dmc_addr_t s, input dmc_addr_t d);
    ch_block_cnt[c] = b;
    ch_burst_len[c] = bl;
    ch_src_mode[c] = sm;
    ch_dst_mode[c] = dm;
    ch_dst_reload[c] = dr;
    ch_src_start[c] = s;
    ch_dst_start[c] = d;
    ch_enable_set[c] = 1'b1;
    tk(1);
    ch_enable_set[c] = 1'b0;
    tk(1);
  endtask : cfg
  task trig(input int c);
    sw_trig[c] = 1'b1;
    tk(1);
    sw_trig[c] = 1'b0;
    tk(1);
  endtask : trig
  task wfl(input int c);
    for (int i = 0; i < 500 && trn_flag[c] !== 1'b1; i++)
      tk(1);
  endtask : wfl
  // disable and clear both flags of a channel
  task done(input int c);
    ch_enable_clr[c] = 1'b1;
    trn_flag_clr[c] = 1'b1;
    err_flag_clr[c] = 1'b1;
    tk(1);
    ch_enable_clr[c] = 1'b0;
    trn_flag_clr[c] = 1'b0;
    err_flag_clr[c] = 1'b0;
    tk(1);
  endtask : done
  task t_block;
    trn_irq_en = 4'h1;
    n0 = n_wr;
    cfg(0, 16'h0005, 2'h2, `DMC_AMODE_INC, `DMC_AMODE_INC, `DMC_RLD_NEVER, 16'h0100, 16'h0200);
    trig(0);
    wfl(0);
    chk(n_wr - n0, 5);
    chk(last_a, 16'h0204);
    chk(last_d, f(16'h0104));
    chk(ch_enabled[0], 1'b0);
    chk(trn_irq[0], 1'b1);
    chk(ch_busy[0], 1'b0);
    cfg(0, 16'h0005, 2'h2, `DMC_AMODE_INC, `DMC_AMODE_INC, `DMC_RLD_NEVER, 16'h0100, 16'h0200);
    tk(30);
    chk(n_wr - n0, 5);
    done(0);
    $display("block test done");
  endtask : t_block
  task t_repeat;
    ch_repeat_en[2] = 1'b1;
    ch_repeat_cnt[2] = 8'h03;
    n0 = n_wr;
    cfg(2, 16'h0002, 2'h0, `DMC_AMODE_STATIC, `DMC_AMODE_INC, `DMC_RLD_BLOCK, 16'h0150, 16'h0400);
    trig(2);
    wfl(2);
    chk(n_wr - n0, 6);
    chk(last_a, 16'h0401);
    chk(last_d, f(16'h0150));
    ch_repeat_en[2] = 1'b0;
    done(2);
    $display("repeat test done");
  endtask : t_repeat
  task t_shot;
    ch_single_shot[1] = 1'b1;
    cpu_bus_req = 1'b1;
    n0 = n_wr;
    cfg(1, 16'h0008, 2'h1, `DMC_AMODE_INC, `DMC_AMODE_DEC, `DMC_RLD_NEVER, 16'h0110, 16'h0300);
    trig(1);
    trig(1);
    trig(1);
    tk(30);
    chk(n_wr - n0, 0);
    chk(ch_pend[1], 1'b1);
    cpu_bus_req = 1'b0;
    tk(60);
    chk(n_wr - n0, 4);
    chk(last_a, 16'h02fd);
    chk(ch_busy[1], 1'b1);
    ch_enable_clr[1] = 1'b1;
    tk(1);
    ch_enable_clr[1] = 1'b0;
    tk(1);
    chk(err_flag[1], 1'b1);
    ch_single_shot[1] = 1'b0;
    done(1);
    $display("single shot test done");
  endtask : t_shot
  task t_ee;
    err_irq_en = 4'h8;
    n0 = n_wr;
    cfg(3, 16'h0001, 2'h0, `DMC_AMODE_INC, `DMC_AMODE_INC, `DMC_RLD_NEVER, 16'h0120, `DMC_EE_FIRST);
    trig(3);
    tk(30);
    chk(err_flag[3], 1'b1);
    chk(err_irq[3], 1'b1);
    chk(n_wr - n0, 0);
    done(3);
    $display("eeprom test done");
  endtask : t_ee
  task t_sel;
    ch_trig_sel[0] = 3'h7;
    n0 = n_wr;
    cfg(0, 16'h0001, 2'h0, `DMC_AMODE_INC, `DMC_AMODE_INC, `DMC_RLD_NEVER, 16'h0130, 16'h0500);
    trig_lines = 8'h80;
    tk(40);
    chk(n_wr - n0, 0);
    ch_trig_sel[0] = 3'h1;
    trig_lines = 8'h02;
    tk(1);
    trig_lines = 8'h00;
    wfl(0);
    chk(n_wr - n0, 1);
    ch_trig_sel[0] = 3'h0;
    done(0);
    $display("trigger select test done");
  endtask : t_sel
  // linked pair 2/3: channel 3 reads the eeprom window after channel 2 ends
  task t_link;
    cfg(3, 16'h0001, 2'h0, `DMC_AMODE_INC, `DMC_AMODE_INC, `DMC_RLD_NEVER, `DMC_EE_FIRST,
        16'h0900);
    done(3);
    n0 = n_wr;
    channel_pair_link_select = 2'h2;
    cfg(2, 16'h0001, 2'h0, `DMC_AMODE_INC, `DMC_AMODE_INC, `DMC_RLD_NEVER, 16'h0160, 16'h0800);
    trig(2);
    wfl(2);
    channel_pair_link_select = 2'h0;
    wfl(3);
    chk(n_wr - n0, 2);
    chk(last_a, 16'h0900);
    chk(last_d, f(`DMC_EE_FIRST));
    chk(ch_enabled[3:2], 2'h0);
    done(2);
    done(3);
    $display("link test done");
  endtask : t_link
  task pri(input logic [1:0] m, input dmc_addr_t e);
    channel_priority_select = m;
    cfg(1, 16'h0001, 2'h0, `DMC_AMODE_INC, `DMC_AMODE_INC, `DMC_RLD_NEVER, 16'h0140, 16'h0600);
    cfg(0, 16'h0001, 2'h0, `DMC_AMODE_INC, `DMC_AMODE_INC, `DMC_RLD_NEVER, 16'h0141, 16'h0700);
    sw_trig = 4'h3;
    tk(1);
    sw_trig = 4'h0;
    for (int i = 0; i < 50 && mem_wr !== 1'b1; i++)
      tk(1);
    chk(mem_addr, e);
    wfl(0);
    wfl(1);
    done(0);
    done(1);
  endtask : pri
  task t_pri;
    cfg(0, 16'h0001, 2'h0, `DMC_AMODE_INC, `DMC_AMODE_INC, `DMC_RLD_NEVER, 16'h0100, 16'h0200);
    trig(0);
    wfl(0);
    done(0);
    pri(`DMC_PRIO_RR0123, 16'h0600);
    pri(`DMC_PRIO_FIXED, 16'h0700);
    $display("priority test done");
  endtask : t_pri
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    results;
  end
  initial begin
    tk(20);
    nrst = 1'b1;
    tk(1);
    chk(ch_enabled, 4'h0);
    chk(ch_pend, 4'h0);
    chk(bus_req, 1'b0);
    t_block;
    t_repeat;
    t_shot;
    t_ee;
    t_sel;
    t_pri;
    t_link;
    results;
  end
endmodule : dmc_top_tb
